// ### ixseq_assertions.sv
// Port checker for the indexed-mode bus sequencer
`timescale 1ns/1ps
module ixseq_assertions
	import ixseq_pkg::*;
(
	input wire logic         mclk,
	input wire logic         arst_n,
	input wire logic         start,
	input wire ixseq_class_t opClass,
	input wire logic [15:0]  opcodeAddr,
	input wire logic [15:0]  indexReg,
	input wire logic [15:0]  stackPtr,
	input wire logic [15:0]  returnAddr,
	input wire logic [15:0]  subAddr,
	input wire logic         valid_memory_strobe,
	input wire logic [15:0]  addrOut,
	input wire logic         readNotWrite,
	input wire logic         dataOe,
	input wire logic         busy,
	input wire logic         done
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	wire        vm = valid_memory_strobe; // Short aliases
	wire        rd = readNotWrite;
	wire [15:0] a  = addrOut;
	wire        go = start && !busy;      // Start taken from idle; bus cycle k at ##(1+k)
	// Data bus driven only while writing
	oe_write_only_a: assert property (dataOe |-> !rd) else $error("drive in read");
	fetch_pair_a: assert property (go |-> ##2 (vm && rd && a == $past(opcodeAddr, 2))
		##1 (vm && rd && a == $past(opcodeAddr, 3) + 16'h0001)) else $error("fetch");
	// Dummy read at the index, not yet offset
	index_dummy_a: assert property (go && opClass != IXSEQ_BSR |->
		##4 (!vm && rd && a == $past(indexReg, 4))) else $error("index dummy");
	jsr_push_a: assert property (go && opClass == IXSEQ_JSR |->
		##5 (vm && !rd && a == $past(stackPtr, 5))
		##1 (vm && !rd && a == $past(stackPtr, 6) - 16'h0001)) else $error("push");
	bsr_tail_a: assert property (go && opClass == IXSEQ_BSR |->
		##7 (!vm && rd && a == $past(stackPtr, 7) - 16'h0002)
		##1 (!vm && rd && a == $past(returnAddr, 8))
		##1 (!vm && rd && a == $past(subAddr, 9))) else $error("bsr tail");
	jmp_end_a: assert property (go && opClass == IXSEQ_JMP |->
		##5 (!vm && rd && done)) else $error("jmp end");
	sta_write_a: assert property (go && opClass == IXSEQ_STA |->
		##6 !vm ##1 (vm && !rd && dataOe && $stable(a))) else $error("sta");
	rmw_write_a: assert property (go && opClass == IXSEQ_RMW |->
		##6 (vm && rd) ##1 !vm ##1 (vm && !rd && a == $past(a, 2))) else $error("rmw");
	// Test operand must leave memory untouched
	tst_end_a: assert property (go && opClass == IXSEQ_TST |->
		##8 (!vm && done)) else $error("tst");
	// Shortest class is four cycles, so done cannot repeat sooner
	done_gap_a: assert property (done |=> !done [*3]) else $error("done gap");
	jsr_cov: cover property (go && opClass == IXSEQ_JSR);
	poke_cov: cover property (start && busy);
	done_cov: cover property (done);
endmodule

// ### ixseq_mem_model.sv
// Bus memory: fill mixed with address low byte, toggles when not read-strobed
`timescale 1ns/1ps
module ixseq_mem_model #(
	parameter logic [7:0] FILL = 8'hF3 // Location holds FILL xor its address low byte
) (
	input  wire logic       mclk,
	input  wire logic       valid_memory_strobe,
	input  wire logic       readNotWrite,
	input  wire logic [15:0] addrOut,
	output logic [7:0]      dataIn
);
	logic [7:0] lastVal_r = 8'h00; // Last value on the bus
	wire        rdSel = valid_memory_strobe && readNotWrite;
	// Address-dependent data, so a capture in the wrong cycle shows up
	wire [7:0]  memByte = FILL ^ addrOut[7:0];
	// Released bus toggles, so stale data never looks valid
	assign dataIn = rdSel ? memByte : ~lastVal_r;
	always_ff @(posedge mclk) lastVal_r <= dataIn;
endmodule

// ### ixseq_pkg.sv
// Package holding sequencer classes, states and cycle counts
package ixseq_pkg;
	// Instruction classes the sequencer serves
	typedef enum logic [3:0] {
		IXSEQ_JMP    = 4'h0, // jump_op indexed
		IXSEQ_ACC    = 4'h1, // accumulator operand read
		IXSEQ_LD16   = 4'h2, // load_stack_pointer, load_index_register, compare
		IXSEQ_STA    = 4'h3, // store_accumulator
		IXSEQ_RMW    = 4'h4, // read-modify-write group
		IXSEQ_TST    = 4'h5, // test_operand
		IXSEQ_ST16   = 4'h6, // store_stack_pointer, store_index_register
		IXSEQ_JSR    = 4'h7, // jump_to_subroutine indexed
		IXSEQ_BSR    = 4'h8  // branch_to_subroutine relative
	} ixseq_class_t;

	// Sequencer state, one-hot
	typedef enum logic [1:0] {
		IXSEQ_IDLE = 2'b01,
		IXSEQ_RUN  = 2'b10
	} ixseq_state_t;

	// Cycle totals per class
	localparam logic [3:0] IXSEQ_N_JMP  = 4'h4;
	localparam logic [3:0] IXSEQ_N_ACC  = 4'h5;
	localparam logic [3:0] IXSEQ_N_LD16 = 4'h6;
	localparam logic [3:0] IXSEQ_N_STA  = 4'h6;
	localparam logic [3:0] IXSEQ_N_RMW  = 4'h7;
	localparam logic [3:0] IXSEQ_N_ST16 = 4'h7;
	localparam logic [3:0] IXSEQ_N_JSR  = 4'h8;
	localparam logic [3:0] IXSEQ_N_BSR  = 4'h8;
	// Reset values
	localparam logic [15:0] IXSEQ_ADDR_RST = 16'h0000;
	localparam logic [7:0]  IXSEQ_DATA_RST = 8'h00;
endpackage

// ### ixseq_top.sv
// Indexed-mode bus sequencer: per-cycle strobe, address, direction and data
// Operation
// - Subroutine-branch cycles 4,5 push return bytes.
// - Subroutine-branch cycles 6-8 strobe low reads.
// - Ignore data bus in irrelevant cycles.
// - Indexed jump: four cycles, two dummy reads.
// - Accumulator read: five cycles, operand last.
// - Sixteen-bit loads: six cycles, high then low.
// - Accumulator store: six cycles, write last.
// - Modify ops: seven cycles, read, dummy, write.
// - Test operand keeps strobe low finally.
// - Sixteen-bit stores: seven cycles, high then low.
// - Indexed subroutine jump: eight cycles, push return.
// - Last three subroutine cycles strobe low reads.
// - Opcode then offset fetched, strobe high.
`timescale 1ns/1ps
module ixseq_top
	import ixseq_pkg::*;
(
	input  wire logic         mclk,
	input  wire logic         arst_n,
	input  wire logic         start,          // Pulse: begin at cycle 1, same clock domain
	input  wire ixseq_class_t opClass,        // Class, sampled with start
	input  wire logic [15:0]  opcodeAddr,     // Address of opcode
	input  wire logic [15:0]  indexReg,       // Index register
	input  wire logic [15:0]  stackPtr,       // Stack pointer
	input  wire logic [15:0]  returnAddr,     // Return address to push
	input  wire logic [15:0]  subAddr,        // Relative subroutine target
	input  wire logic [15:0]  storeWord,      // Register for 16-bit stores
	input  wire logic [7:0]   accData,        // Accumulator for store
	input  wire logic [7:0]   newOperand,     // Modified operand value
	input  wire logic [7:0]   dataIn,         // Data bus input
	output logic              valid_memory_strobe,
	output logic [15:0]       addrOut,
	output logic              readNotWrite,
	output logic [7:0]        dataOut,
	output logic              dataOe,         // High while driving data bus
	output logic [7:0]        offsetByte,     // Captured offset
	output logic [7:0]        operandHi,      // Captured operand / high byte
	output logic [7:0]        operandLo,      // Captured low byte
	output logic              busy,
	output logic              done            // Pulse in last cycle
);
	ixseq_state_t state_r, state_nxt;
	ixseq_class_t cls_r;                      // Latched class
	logic [3:0]   cyc_r, cyc_nxt;             // Current cycle number, 1-based
	logic [15:0]  op_r, ix_r, sp_r, ret_r, sub_r, sw_r;
	logic [7:0]   acc_r, off_r, hi_r, lo_r;

	// Address arithmetic; offset taken unsigned
	wire [15:0] noCarryAddr = {ix_r[15:8], 8'(ix_r[7:0] + off_r)};
	wire [15:0] effAddr     = 16'(ix_r + {8'h00, off_r});
	wire [15:0] effAddr1    = 16'(effAddr + 16'h0001);

	wire [3:0] lastCyc =
		(cls_r == IXSEQ_JMP)  ? IXSEQ_N_JMP  :
		(cls_r == IXSEQ_ACC)  ? IXSEQ_N_ACC  :
		(cls_r == IXSEQ_LD16) ? IXSEQ_N_LD16 :
		(cls_r == IXSEQ_STA)  ? IXSEQ_N_STA  :
		(cls_r == IXSEQ_ST16) ? IXSEQ_N_ST16 :
		(cls_r == IXSEQ_JSR)  ? IXSEQ_N_JSR  :
		(cls_r == IXSEQ_BSR)  ? IXSEQ_N_BSR  : IXSEQ_N_RMW;

	// Per-cycle bus plan, combinational
	logic        vma_c, rd_c, oe_c;
	logic [15:0] ad_c;
	logic [7:0]  do_c;
	always_comb begin
		vma_c = 1'b1;
		rd_c  = 1'b1;
		oe_c  = 1'b0;
		ad_c  = op_r;
		do_c  = IXSEQ_DATA_RST;
		if (cyc_r == 4'h1) begin
			ad_c = op_r;
		end else if (cyc_r == 4'h2) begin
			ad_c = 16'(op_r + 16'h0001);
		end else if (cls_r == IXSEQ_BSR) begin
			// Relative subroutine branch tail
			unique case (cyc_r)
				4'h3: begin vma_c = 1'b0; ad_c = ret_r; end
				4'h4: begin rd_c = 1'b0; oe_c = 1'b1; ad_c = sp_r; do_c = ret_r[7:0]; end
				4'h5: begin
					rd_c = 1'b0; oe_c = 1'b1;
					ad_c = 16'(sp_r - 16'h0001);
					do_c = ret_r[15:8];
				end
				4'h6: begin vma_c = 1'b0; ad_c = 16'(sp_r - 16'h0002); end
				4'h7: begin vma_c = 1'b0; ad_c = ret_r; end
				default: begin vma_c = 1'b0; ad_c = sub_r; end
			endcase
		end else if (cls_r == IXSEQ_JSR) begin
			unique case (cyc_r)
				4'h3: begin vma_c = 1'b0; ad_c = ix_r; end
				4'h4: begin rd_c = 1'b0; oe_c = 1'b1; ad_c = sp_r; do_c = ret_r[7:0]; end
				4'h5: begin
					rd_c = 1'b0; oe_c = 1'b1;
					ad_c = 16'(sp_r - 16'h0001);
					do_c = ret_r[15:8];
				end
				4'h6: begin vma_c = 1'b0; ad_c = 16'(sp_r - 16'h0002); end
				4'h7: begin vma_c = 1'b0; ad_c = ix_r; end
				default: begin vma_c = 1'b0; ad_c = noCarryAddr; end
			endcase
		end else if (cyc_r == 4'h3) begin
			vma_c = 1'b0;
			ad_c  = ix_r;
		end else if (cyc_r == 4'h4) begin
			vma_c = 1'b0;
			ad_c  = noCarryAddr;
		end else begin
			ad_c = effAddr;
			unique case (cls_r)
				IXSEQ_LD16: if (cyc_r == 4'h6) ad_c = effAddr1;
				IXSEQ_STA: if (cyc_r == 4'h5) vma_c = 1'b0;
					else begin rd_c = 1'b0; oe_c = 1'b1; do_c = acc_r; end
				IXSEQ_RMW, IXSEQ_TST: begin
					if (cyc_r == 4'h6) vma_c = 1'b0;
					else if (cyc_r == 4'h7) begin
						vma_c = (cls_r != IXSEQ_TST);
						rd_c  = 1'b0;
						oe_c  = 1'b1;
						do_c  = newOperand;
					end
				end
				IXSEQ_ST16: begin
					if (cyc_r == 4'h5) vma_c = 1'b0;
					else begin
						rd_c = 1'b0;
						oe_c = 1'b1;
						ad_c = (cyc_r == 4'h7) ? effAddr1 : effAddr;
						do_c = (cyc_r == 4'h7) ? sw_r[7:0] : sw_r[15:8];
					end
				end
				default: vma_c = 1'b1;
			endcase
		end
	end

	// Capture enables: only strobe-high read cycles load data
	wire capOff = (state_r == IXSEQ_RUN) && (cyc_r == 4'h2);
	wire capHi  = (state_r == IXSEQ_RUN) && (cyc_r == 4'h5) && (cls_r != IXSEQ_BSR)
		&& (cls_r != IXSEQ_JSR) && (cls_r != IXSEQ_STA) && (cls_r != IXSEQ_ST16);
	wire capLo  = (state_r == IXSEQ_RUN) && (cyc_r == 4'h6) && (cls_r == IXSEQ_LD16);
	wire isLast = (state_r == IXSEQ_RUN) && (cyc_r == lastCyc);

	// Next state and cycle counter
	always_comb begin
		state_nxt = state_r;
		cyc_nxt   = cyc_r;
		unique case (state_r)
			IXSEQ_IDLE: if (start) begin
				state_nxt = IXSEQ_RUN;
				cyc_nxt   = 4'h1;
			end
			IXSEQ_RUN: if (isLast) begin
				// Back-to-back start goes straight to cycle 1
				state_nxt = start ? IXSEQ_RUN : IXSEQ_IDLE;
				cyc_nxt   = start ? 4'h1 : 4'h0;
			end else begin
				cyc_nxt = 4'(cyc_r + 4'h1);
			end
			default: begin
				state_nxt = IXSEQ_IDLE;
				cyc_nxt   = 4'h0;
			end
		endcase
	end
	wire takeStart = start && ((state_r == IXSEQ_IDLE) || isLast);

	// Control state
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= IXSEQ_IDLE;
			cyc_r   <= 4'h0;
		end else begin
			state_r <= state_nxt;
			cyc_r   <= cyc_nxt;
		end
	end

	// Operand context latched at start
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cls_r <= IXSEQ_JMP;
			op_r  <= IXSEQ_ADDR_RST;
			ix_r  <= IXSEQ_ADDR_RST;
			sp_r  <= IXSEQ_ADDR_RST;
			ret_r <= IXSEQ_ADDR_RST;
			sub_r <= IXSEQ_ADDR_RST;
			sw_r  <= IXSEQ_ADDR_RST;
			acc_r <= IXSEQ_DATA_RST;
		end else if (takeStart) begin
			cls_r <= opClass;
			op_r  <= opcodeAddr;
			ix_r  <= indexReg;
			sp_r  <= stackPtr;
			ret_r <= returnAddr;
			sub_r <= subAddr;
			sw_r  <= storeWord;
			acc_r <= accData;
		end
	end

	// Capture flags delayed one clock: the bus shows a plan cycle one clock late,
	// so the memory answers then; sampling earlier would catch the previous bus cycle
	logic capOff_r;                           // Bus now shows the offset fetch
	logic capHi_r;                            // Bus now shows operand / high byte read
	logic capLo_r;                            // Bus now shows low byte read
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			capOff_r <= 1'b0;
			capHi_r  <= 1'b0;
			capLo_r  <= 1'b0;
		end else begin
			capOff_r <= capOff;
			capHi_r  <= capHi;
			capLo_r  <= capLo;
		end
	end

	// Data captures from the bus, at the end of the matching bus cycle
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			off_r <= IXSEQ_DATA_RST;
			hi_r  <= IXSEQ_DATA_RST;
			lo_r  <= IXSEQ_DATA_RST;
		end else begin
			if (capOff_r) off_r <= dataIn;
			if (capHi_r) hi_r <= dataIn;
			if (capLo_r) lo_r <= dataIn;
		end
	end

	// Registered bus outputs; plan is for the cycle now running
	wire runNxt = (state_nxt == IXSEQ_RUN);
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			valid_memory_strobe <= 1'b0;
			addrOut             <= IXSEQ_ADDR_RST;
			readNotWrite        <= 1'b1;
			dataOut             <= IXSEQ_DATA_RST;
			dataOe              <= 1'b0;
			busy                <= 1'b0;
			done                <= 1'b0;
		end else begin
			valid_memory_strobe <= (state_r == IXSEQ_RUN) && vma_c;
			addrOut             <= ad_c;
			readNotWrite        <= (state_r != IXSEQ_RUN) || rd_c;
			dataOut             <= do_c;
			dataOe              <= (state_r == IXSEQ_RUN) && oe_c;
			busy                <= runNxt;
			done                <= isLast;
		end
	end

	// Captured bytes out
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			offsetByte <= IXSEQ_DATA_RST;
			operandHi  <= IXSEQ_DATA_RST;
			operandLo  <= IXSEQ_DATA_RST;
		end else begin
			offsetByte <= off_r;
			operandHi  <= hi_r;
			operandLo  <= lo_r;
		end
	end

endmodule

// ### ixseq_top_test.sv
// Testbench for the indexed-mode bus sequencer
`timescale 1ns/1ps
module ixseq_top_test;
	import ixseq_pkg::*;
	localparam logic [7:0] OFS = 8'hF3; // Byte the offset fetch returns (its address low byte is 00)
	typedef struct { ixseq_class_t c; logic [3:0] n; logic [15:0] x; } ixseq_row_t;
	logic mclk = 1'b0, arst_n = 1'b0, start = 1'b0;
	ixseq_class_t opClass = IXSEQ_JMP;
	logic [15:0] opcodeAddr = 16'h80FF, indexReg = 16'h0000, stackPtr = 16'h01FF;
	logic [15:0] returnAddr = 16'h8123, subAddr = 16'h9456, storeWord = 16'hA55A;
	logic [7:0]  accData = 8'h3C, newOperand = 8'hC3, dataIn, dataOut, offsetByte;
	logic [7:0]  operandHi, operandLo;
	logic [15:0] addrOut;
	logic        valid_memory_strobe, readNotWrite, dataOe, busy, done;
	int          error_cnt = 0, checked = 0;
	ixseq_row_t  rows [9] = '{'{IXSEQ_JMP, IXSEQ_N_JMP, 16'h12F0},
		'{IXSEQ_ACC, IXSEQ_N_ACC, 16'h1210}, '{IXSEQ_LD16, IXSEQ_N_LD16, 16'h34FE},
		'{IXSEQ_STA, IXSEQ_N_STA, 16'h0010}, '{IXSEQ_RMW, IXSEQ_N_RMW, 16'hFFF0},
		'{IXSEQ_TST, IXSEQ_N_RMW, 16'h2020}, '{IXSEQ_ST16, IXSEQ_N_ST16, 16'h12F0},
		'{IXSEQ_JSR, IXSEQ_N_JSR, 16'h40F8}, '{IXSEQ_BSR, IXSEQ_N_BSR, 16'h5000}};
	ixseq_top dut (.mclk, .arst_n, .start, .opClass, .opcodeAddr, .indexReg, .stackPtr,
		.returnAddr, .subAddr, .storeWord, .accData, .newOperand, .dataIn,
		.valid_memory_strobe, .addrOut, .readNotWrite, .dataOut, .dataOe, .offsetByte,
		.operandHi, .operandLo, .busy, .done);
	ixseq_mem_model #(.FILL(OFS)) mem (.mclk, .valid_memory_strobe, .readNotWrite, .addrOut,
		.dataIn);
	always #4 mclk = ~mclk; // 125 MHz
	// Expected {strobe, read, address, write data} of bus cycle k
	function automatic logic [25:0] plan(ixseq_class_t c, int k);
		logic [15:0] e, n;
		logic jb;
		e = indexReg + {8'h00, OFS}; // Full sum, carry applied
		n = {indexReg[15:8], indexReg[7:0] + OFS}; // No-carry dummy
		jb = c inside {IXSEQ_JSR, IXSEQ_BSR};
		case (k)
			1: return {2'h3, opcodeAddr, 8'h00};
			2: return {2'h3, opcodeAddr + 16'h0001, 8'h00};
			3: return {2'h1, c == IXSEQ_BSR ? returnAddr : indexReg, 8'h00};
			4: return jb ? {2'h2, stackPtr, returnAddr[7:0]} : {2'h1, n, 8'h00};
			5: return jb ? {2'h2, stackPtr - 16'h0001, returnAddr[15:8]} :
				{c inside {IXSEQ_ACC, IXSEQ_LD16, IXSEQ_RMW, IXSEQ_TST}, 1'b1, e, 8'h00};
			6: return jb ? {2'h1, stackPtr - 16'h0002, 8'h00} :
				c == IXSEQ_LD16 ? {2'h3, e + 16'h0001, 8'h00} :
				c == IXSEQ_STA ? {2'h2, e, accData} :
				c == IXSEQ_ST16 ? {2'h2, e, storeWord[15:8]} : {2'h1, e, 8'h00};
			7: return jb ? {2'h1, c == IXSEQ_BSR ? returnAddr : indexReg, 8'h00} :
				c == IXSEQ_ST16 ? {2'h2, e + 16'h0001, storeWord[7:0]} :
				{c == IXSEQ_RMW, 1'b0, e, newOperand};
			default: return {2'h1, c == IXSEQ_BSR ? subAddr : n, 8'h00};
		endcase
	endfunction
	task automatic check(string what, logic [25:0] want, logic [25:0] got);
		checked++;
		if (want !== got) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, want, got);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// One sequence; poke fires a start mid-run that must be ignored
	task automatic run(ixseq_row_t r, logic poke);
		logic [25:0] w;
		logic [15:0] e;
		@(posedge mclk);
		opClass <= r.c;
		indexReg <= r.x;
		start <= 1'b1;
		@(posedge mclk);
		start <= 1'b0;
		// Bus cycle 1 stands in the second clock after the start edge
		@(posedge mclk);
		for (int k = 1; k <= r.n; k++) begin
			@(negedge mclk);
			w = plan(r.c, k);
			check("bus", w, {valid_memory_strobe, readNotWrite, addrOut,
				dataOe ? dataOut : 8'h00});
			check("done", 26'(k == r.n), 26'(done));
			if (w[24] || w[25]) begin
				check("drive", 26'(!w[24]), 26'(dataOe));
			end
			if (k < r.n) begin
				@(posedge mclk);
				start <= poke && k == 3;
			end
		end
		// Captured bytes reach the outputs two clocks after their bus cycle
		repeat (2) @(negedge mclk);
		e = r.x + {8'h00, OFS};
		if (r.c inside {IXSEQ_ACC, IXSEQ_LD16, IXSEQ_RMW, IXSEQ_TST}) begin
			check("operand hi", 26'(OFS ^ e[7:0]), 26'(operandHi));
		end
		if (r.c == IXSEQ_LD16) begin
			check("operand lo", 26'(OFS ^ 8'(e + 16'h0001)), 26'(operandLo));
		end
		$display("test class %0d ended", r.c);
	endtask
	initial begin
		repeat (8) @(posedge mclk);
		arst_n <= 1'b1;
		for (int i = 0; i < 9; i++) begin
			run(rows[i], i == 7);
		end
		check("offset", 26'(OFS), 26'(offsetByte));
		// Reset in mid-sequence, then a full run again
		@(posedge mclk);
		opClass <= IXSEQ_JSR;
		start <= 1'b1;
		@(posedge mclk);
		start <= 1'b0;
		repeat (5) @(posedge mclk);
		arst_n <= 1'b0;
		@(negedge mclk);
		check("reset", 26'h008_0000, 26'({valid_memory_strobe, readNotWrite, dataOe, busy,
			done, addrOut}));
		@(posedge mclk);
		arst_n <= 1'b1;
		run(rows[7], 1'b0);
		$display("test reset ended");
		tally_and_finish();
	end
	// Watchdog: all tests need well under 2000 cycles
	initial begin
		repeat (2000) @(posedge mclk);
		error_cnt++;
		tally_and_finish();
	end
endmodule
bind ixseq_top ixseq_assertions chk (.mclk, .arst_n, .start, .opClass, .opcodeAddr,
	.indexReg, .stackPtr, .returnAddr, .subAddr, .valid_memory_strobe, .addrOut,
	.readNotWrite, .dataOe, .busy, .done);
